// ### inc/channel_clock_divider_pkg.sv
/*
  Constants and types for the output-channel clock divider: register
  addresses, field positions, reset values and divider states.
  Assumes the register port addresses registers at their printed offsets.
*/
// Overview of operation
// - The output stays low for the low-count field plus one input cycles.
// - The output stays high for the high-count field plus one input cycles.
// - Bypass stops the divider and routes the input clock to the output.
// - The divider obeys the chip sync signal unless ignore-sync is set.
// - The forced level acts only while ignore-sync is also set.
// - When forcing applies outside bypass the output is static at the force-high bit.
// - The start-polarity bit picks whether the divided clock starts high.
// - A four-bit phase offset delays the start of the divided clock.
// - Channel 3 power-down puts its three output pairs into high impedance.
// - Channel 2 power-down puts its three output pairs into high impedance.
// - Channel 3 duty-cycle correction is on unless its disable bit is set.
// - Channel 2 duty-cycle correction is on unless its disable bit is set.
package channel_clock_divider_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int PAIRS = 3;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_DIV3_PHASE_LENGTHS = 10'h099;
  localparam logic [ADDR_W-1:0] ADDR_DIV3_CONTROL = 10'h09a;
  localparam logic [ADDR_W-1:0] ADDR_CH3_POWER_CORR = 10'h09b;
  localparam logic [ADDR_W-1:0] ADDR_CH2_POWER_CORR = 10'h198;

  // Reset values
  localparam logic [DATA_W-1:0] RST_DIV3_PHASE_LENGTHS = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIV3_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_POWER_CORR = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Field positions
  localparam int LOW_HI = 7;
  localparam int LOW_LO = 4;
  localparam int HIGH_HI = 3;
  localparam int HIGH_LO = 0;
  localparam int BIT_BYPASS = 7;
  localparam int BIT_IGNORE_SYNC = 6;
  localparam int BIT_FORCE_HIGH = 5;
  localparam int BIT_START_HIGH = 4;
  localparam int OFFSET_HI = 3;
  localparam int OFFSET_LO = 0;
  localparam int BIT_POWER_DOWN = 2;
  localparam int BIT_CORR_DISABLE = 0;

  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_RUN
  } div_state_t;

endpackage : channel_clock_divider_pkg

// ### hw/sync_2ff.sv
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the level is held far longer than one clock period.
*/
`timescale 1ns/100ps
module sync_2ff (
  input wire logic clk_sys_in, // System clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic rst_val_in, // Value taken during reset
  input wire logic d_in, // Asynchronous level
  output logic q_out // Synchronised level
);

  logic meta_q;
  logic sync_q;

  // First flop feeds only the second
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      meta_q <= rst_val_in;
      sync_q <= rst_val_in;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule : sync_2ff

// ### hw/channel_clock_divider.sv
/*
  Divider 3 of the clock distribution with its control registers and the
  power-down and duty-cycle controls of channels 2 and 3.
  Assumes clk_sys_in is the channel input clock and the register port is
  driven from logic on the same clock; the sync pin is asynchronous.
*/
`timescale 1ns/100ps
module channel_clock_divider (
  input wire logic clk_sys_in, // Channel input clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic sync_n_in, // Chip-level sync pin, active low
  input wire logic [9:0] reg_addr_in, // Register address
  input wire logic [7:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Register write strobe
  input wire logic reg_rd_in, // Register read strobe
  output logic [7:0] reg_rdata_out, // Read data, one cycle after strobe
  output logic div_clk_out, // Divider output clock
  output logic div_powered_out, // Divider counting logic in use
  output logic [2:0] ch3_oe_out, // Channel 3 output pair enables
  output logic [2:0] ch2_oe_out, // Channel 2 output pair enables
  output logic ch3_duty_cycle_correction_out, // Channel 3 correction on
  output logic ch2_duty_cycle_correction_out // Channel 2 correction on
);

  typedef struct packed {
    logic [channel_clock_divider_pkg::CNT_W-1:0] low_cnt;
    logic [channel_clock_divider_pkg::CNT_W-1:0] high_cnt;
    logic bypass;
    logic ignore_sync;
    logic force_high;
    logic start_high;
    logic [channel_clock_divider_pkg::CNT_W-1:0] offset;
    logic ch3_pd;
    logic ch3_corr_dis;
    logic ch2_pd;
    logic ch2_corr_dis;
    channel_clock_divider_pkg::div_state_t state;
    logic [channel_clock_divider_pkg::CNT_W-1:0] cnt;
    logic level;
    logic out;
    logic [channel_clock_divider_pkg::DATA_W-1:0] rdata;
  } div_regs_t;

  div_regs_t st_q;
  div_regs_t st_d;
  logic sync_n_s;
  logic sync_act;
  logic force_now;
  logic [channel_clock_divider_pkg::CNT_W-1:0] limit;
  localparam int PAIRS_OF = channel_clock_divider_pkg::PAIRS;

  // Sync pin crosses into the clock domain before use
  sync_2ff u_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .rst_val_in(1'b1),
    .d_in(sync_n_in),
    .q_out(sync_n_s)
  );

  assign sync_act = ~sync_n_s;
  assign force_now = st_q.ignore_sync & sync_act;
  assign limit = st_q.level ? st_q.high_cnt : st_q.low_cnt;

  // Register writes, reads and the divider state machine
  always_comb begin
    st_d = st_q;
    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        channel_clock_divider_pkg::ADDR_DIV3_PHASE_LENGTHS: begin
          st_d.low_cnt = reg_wdata_in[channel_clock_divider_pkg::LOW_HI:
                                      channel_clock_divider_pkg::LOW_LO];
          st_d.high_cnt = reg_wdata_in[channel_clock_divider_pkg::HIGH_HI:
                                       channel_clock_divider_pkg::HIGH_LO];
        end
        channel_clock_divider_pkg::ADDR_DIV3_CONTROL: begin
          st_d.bypass = reg_wdata_in[channel_clock_divider_pkg::BIT_BYPASS];
          st_d.ignore_sync =
            reg_wdata_in[channel_clock_divider_pkg::BIT_IGNORE_SYNC];
          st_d.force_high =
            reg_wdata_in[channel_clock_divider_pkg::BIT_FORCE_HIGH];
          st_d.start_high =
            reg_wdata_in[channel_clock_divider_pkg::BIT_START_HIGH];
          st_d.offset = reg_wdata_in[channel_clock_divider_pkg::OFFSET_HI:
                                     channel_clock_divider_pkg::OFFSET_LO];
        end
        channel_clock_divider_pkg::ADDR_CH3_POWER_CORR: begin
          st_d.ch3_pd =
            reg_wdata_in[channel_clock_divider_pkg::BIT_POWER_DOWN];
          st_d.ch3_corr_dis =
            reg_wdata_in[channel_clock_divider_pkg::BIT_CORR_DISABLE];
        end
        channel_clock_divider_pkg::ADDR_CH2_POWER_CORR: begin
          st_d.ch2_pd =
            reg_wdata_in[channel_clock_divider_pkg::BIT_POWER_DOWN];
          st_d.ch2_corr_dis =
            reg_wdata_in[channel_clock_divider_pkg::BIT_CORR_DISABLE];
        end
        default: begin
        end
      endcase
    end
    // Registered read data; unmapped and reserved bits read zero
    if (reg_rd_in) begin
      st_d.rdata = channel_clock_divider_pkg::READ_ZERO;
      case (reg_addr_in)
        channel_clock_divider_pkg::ADDR_DIV3_PHASE_LENGTHS: begin
          st_d.rdata = {st_q.low_cnt, st_q.high_cnt};
        end
        channel_clock_divider_pkg::ADDR_DIV3_CONTROL: begin
          st_d.rdata = {st_q.bypass, st_q.ignore_sync, st_q.force_high,
                        st_q.start_high, st_q.offset};
        end
        channel_clock_divider_pkg::ADDR_CH3_POWER_CORR: begin
          st_d.rdata[channel_clock_divider_pkg::BIT_POWER_DOWN] = st_q.ch3_pd;
          st_d.rdata[channel_clock_divider_pkg::BIT_CORR_DISABLE] =
            st_q.ch3_corr_dis;
        end
        channel_clock_divider_pkg::ADDR_CH2_POWER_CORR: begin
          st_d.rdata[channel_clock_divider_pkg::BIT_POWER_DOWN] = st_q.ch2_pd;
          st_d.rdata[channel_clock_divider_pkg::BIT_CORR_DISABLE] =
            st_q.ch2_corr_dis;
        end
        default: begin
        end
      endcase
    end
    // Divider; a sync pulse under ignore-sync never restarts it
    case (st_q.state)
      channel_clock_divider_pkg::ST_HOLD: begin
        st_d.level = st_q.start_high;
        st_d.cnt = channel_clock_divider_pkg::CNT_ONE;
        if (!st_q.bypass && !(sync_act && !st_q.ignore_sync)) begin
          if (st_q.offset == channel_clock_divider_pkg::CNT_ZERO) begin
            st_d.state = channel_clock_divider_pkg::ST_RUN;
            st_d.cnt = channel_clock_divider_pkg::CNT_ZERO;
          end else begin
            st_d.state = channel_clock_divider_pkg::ST_DELAY;
          end
        end
      end
      channel_clock_divider_pkg::ST_DELAY: begin
        // Output parked at the start level while the offset runs out
        if (st_q.cnt == st_q.offset) begin
          st_d.state = channel_clock_divider_pkg::ST_RUN;
          st_d.cnt = channel_clock_divider_pkg::CNT_ZERO;
        end else begin
          st_d.cnt = st_q.cnt + channel_clock_divider_pkg::CNT_ONE;
        end
      end
      channel_clock_divider_pkg::ST_RUN: begin
        // Each phase lasts its count plus one; period is their sum
        if (st_q.cnt == limit) begin
          st_d.level = ~st_q.level;
          st_d.cnt = channel_clock_divider_pkg::CNT_ZERO;
        end else begin
          st_d.cnt = st_q.cnt + channel_clock_divider_pkg::CNT_ONE;
        end
      end
      default: begin
        st_d.state = channel_clock_divider_pkg::ST_HOLD;
      end
    endcase
    // Sync or bypass sends the divider back to its start
    if (st_q.bypass || (sync_act && !st_q.ignore_sync)) begin
      st_d.state = channel_clock_divider_pkg::ST_HOLD;
    end
    st_d.out = force_now ? st_q.force_high : st_d.level;
  end

  // Single state register
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_q <= '{
        low_cnt: channel_clock_divider_pkg::RST_DIV3_PHASE_LENGTHS[
                   channel_clock_divider_pkg::LOW_HI:
                   channel_clock_divider_pkg::LOW_LO],
        high_cnt: channel_clock_divider_pkg::RST_DIV3_PHASE_LENGTHS[
                    channel_clock_divider_pkg::HIGH_HI:
                    channel_clock_divider_pkg::HIGH_LO],
        bypass: 1'b0,
        ignore_sync: 1'b0,
        force_high: 1'b0,
        start_high: 1'b0,
        offset: channel_clock_divider_pkg::CNT_ZERO,
        ch3_pd: 1'b0,
        ch3_corr_dis: 1'b0,
        ch2_pd: 1'b0,
        ch2_corr_dis: 1'b0,
        state: channel_clock_divider_pkg::ST_HOLD,
        cnt: channel_clock_divider_pkg::CNT_ZERO,
        level: 1'b0,
        out: 1'b0,
        rdata: channel_clock_divider_pkg::READ_ZERO
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Bypass passes the raw clock; the mux may glitch when bypass changes
  assign div_clk_out = st_q.bypass ? clk_sys_in : st_q.out;
  assign div_powered_out = ~st_q.bypass;
  assign ch3_oe_out = {PAIRS_OF{~st_q.ch3_pd}};
  assign ch2_oe_out = {PAIRS_OF{~st_q.ch2_pd}};
  assign ch3_duty_cycle_correction_out = ~st_q.ch3_corr_dis;
  assign ch2_duty_cycle_correction_out = ~st_q.ch2_corr_dis;
  assign reg_rdata_out = st_q.rdata;

  // Helper counters for the checks: phase length and offset length
  logic [4:0] ph_len_q;
  logic [3:0] dly_len_q;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in || st_q.state != channel_clock_divider_pkg::ST_RUN) begin
      ph_len_q <= 5'h01;
    end else if (st_d.level != st_q.level) begin
      ph_len_q <= 5'h01;
    end else begin
      ph_len_q <= ph_len_q + 5'h01;
    end
    if (srst_in || st_q.state != channel_clock_divider_pkg::ST_DELAY) begin
      dly_len_q <= 4'h0;
    end else begin
      dly_len_q <= dly_len_q + 4'h1;
    end
  end

  logic in_run;
  assign in_run = st_q.state == channel_clock_divider_pkg::ST_RUN;

  a_low_phase_len: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (in_run && $past(in_run) && $rose(st_q.level))
      |-> $past(ph_len_q) == {1'b0, st_q.low_cnt} + 5'h01)
    else $error("low phase length wrong");

  a_high_phase_len: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (in_run && $past(in_run) && $fell(st_q.level))
      |-> $past(ph_len_q) == {1'b0, st_q.high_cnt} + 5'h01)
    else $error("high phase length wrong");

  a_bypass_stops_div: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) st_q.bypass
      |=> st_q.state == channel_clock_divider_pkg::ST_HOLD)
    else $error("divider counts in bypass");

  a_sync_holds_div: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (sync_act && !st_q.ignore_sync)
      |=> st_q.state == channel_clock_divider_pkg::ST_HOLD)
    else $error("sync did not hold divider");

  a_ignore_keeps_run: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (in_run && st_q.ignore_sync && !st_q.bypass
      && !reg_wr_in) |=> in_run)
    else $error("ignored sync stopped divider");

  a_force_level: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) force_now |=> st_q.out == $past(st_q.force_high))
    else $error("forced level wrong");

  a_no_force_alone: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) !st_q.ignore_sync |=> st_q.out == st_q.level)
    else $error("forced without ignore sync");

  a_start_polarity: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (in_run && !$past(in_run))
      |-> st_q.level == st_q.start_high)
    else $error("wrong start phase");

  a_phase_offset: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (in_run && $past(st_q.state)
      == channel_clock_divider_pkg::ST_DELAY) |-> dly_len_q == st_q.offset)
    else $error("phase offset length wrong");

  a_pd_tristate: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (reg_wr_in && reg_addr_in ==
      channel_clock_divider_pkg::ADDR_CH3_POWER_CORR) |=> ch3_oe_out ==
      {PAIRS_OF{~$past(
        reg_wdata_in[channel_clock_divider_pkg::BIT_POWER_DOWN])}})
    else $error("channel 3 enables wrong");

  a_ch2_pd_oe: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (reg_wr_in && reg_addr_in ==
      channel_clock_divider_pkg::ADDR_CH2_POWER_CORR) |=> ch2_oe_out ==
      {PAIRS_OF{~$past(
        reg_wdata_in[channel_clock_divider_pkg::BIT_POWER_DOWN])}})
    else $error("channel 2 enables wrong");

  a_ch3_corr_ctrl: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (reg_wr_in && reg_addr_in ==
      channel_clock_divider_pkg::ADDR_CH3_POWER_CORR)
      |=> ch3_duty_cycle_correction_out ==
      ~$past(reg_wdata_in[channel_clock_divider_pkg::BIT_CORR_DISABLE]))
    else $error("channel 3 correction wrong");

  a_ch2_corr_ctrl: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) (reg_wr_in && reg_addr_in ==
      channel_clock_divider_pkg::ADDR_CH2_POWER_CORR)
      |=> ch2_duty_cycle_correction_out ==
      ~$past(reg_wdata_in[channel_clock_divider_pkg::BIT_CORR_DISABLE]))
    else $error("channel 2 correction wrong");

  c_full_period: cover property (@(posedge clk_sys_in)
    in_run && $rose(st_q.level) && st_q.low_cnt != st_q.high_cnt);
  c_offset_start: cover property (@(posedge clk_sys_in)
    in_run && $past(st_q.state) == channel_clock_divider_pkg::ST_DELAY);
  c_forced_high: cover property (@(posedge clk_sys_in)
    force_now && st_q.force_high);
  c_sync_hold: cover property (@(posedge clk_sys_in)
    sync_act && !st_q.ignore_sync &&
    st_q.state == channel_clock_divider_pkg::ST_HOLD);

endmodule : channel_clock_divider

// ### testbench/clock_consumer_model.sv
/*
  Behavioural model of a converter clocked by the divider output.
  Assumes the divided clock is sampled on the channel input clock.
*/
`timescale 1ns/100ps
module clock_consumer_model (
  input wire logic clk_sys_in, // Channel input clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic div_clk_in, // Divided clock seen by the consumer
  output logic [5:0] low_len_out, // Last whole low phase, input cycles
  output logic [5:0] high_len_out // Last whole high phase, input cycles
);
  logic prev_q;
  logic [5:0] run_q;

  // Phase lengths are measured edge to edge; a partial first phase is
  // overwritten by later whole ones, so readers wait a few periods
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      prev_q <= 1'b0;
      run_q <= 6'h01;
      low_len_out <= 6'h00;
      high_len_out <= 6'h00;
    end else if (div_clk_in !== prev_q) begin
      if (prev_q) begin
        high_len_out <= run_q;
      end else begin
        low_len_out <= run_q;
      end
      run_q <= 6'h01;
      prev_q <= div_clk_in;
    end else if (run_q != 6'h3f) begin
      run_q <= run_q + 6'h01; // Saturates so a stuck clock stays visible
    end
  end
endmodule : clock_consumer_model

// ### testbench/testbench.sv
/*
  Self-checking bench for the channel clock divider.
  Assumes the design package is compiled first; inputs move 1 ns after
  each rising clock edge.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module testbench;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic sync_n_in = 1'b1;
  logic [9:0] reg_addr_in = 10'h000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic div_clk_out, div_powered_out;
  logic [2:0] ch3_oe_out, ch2_oe_out;
  logic ch3_duty_cycle_correction_out, ch2_duty_cycle_correction_out;
  logic [5:0] low_len, high_len;
  logic [7:0] rd;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  int n0, n1;
  typedef struct {logic [7:0] cfg; logic [5:0] lo; logic [5:0] hi;} row_t;
  row_t rows [5] = '{'{8'h00, 6'h01, 6'h01}, '{8'h21, 6'h03, 6'h02},
    '{8'hf0, 6'h10, 6'h01}, '{8'h0f, 6'h01, 6'h10}, '{8'hff, 6'h10, 6'h10}};

  channel_clock_divider DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .sync_n_in(sync_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .div_clk_out(div_clk_out), .div_powered_out(div_powered_out),
    .ch3_oe_out(ch3_oe_out), .ch2_oe_out(ch2_oe_out),
    .ch3_duty_cycle_correction_out(ch3_duty_cycle_correction_out),
    .ch2_duty_cycle_correction_out(ch2_duty_cycle_correction_out));
  clock_consumer_model consumer (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .div_clk_in(div_clk_out), .low_len_out(low_len),
    .high_len_out(high_len));

  // 50 MHz clock
  always #10 clk_sys_in = ~clk_sys_in;

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick

  // Strobes drop for a cycle between accesses so no input moves twice
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    tick(1);
    reg_wr_in = 1'b0;
    tick(1);
  endtask : reg_wr

  task automatic reg_rd(input logic [9:0] a, output logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    tick(1);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
    tick(1);
  endtask : reg_rd

  // Output must not move for eight cycles
  task automatic chk_static(input logic exp, input string nm);
    repeat (8) begin
      tick(1);
      `CHK(nm, exp, div_clk_out)
    end
  endtask : chk_static

  // Cycles from sync release until the output first goes low
  task automatic first_fall(output int n);
    n = 0;
    sync_n_in = 1'b1;
    tick(1);
    while (div_clk_out !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
  endtask : first_fall

  initial begin
    tick(5);
    srst_in = 1'b0;
    // Reset values and unmapped address
    reg_rd(channel_clock_divider_pkg::ADDR_DIV3_PHASE_LENGTHS, rd);
    `CHK("phase_lengths", 8'h00, rd)
    reg_rd(channel_clock_divider_pkg::ADDR_DIV3_CONTROL, rd);
    `CHK("control", 8'h00, rd)
    reg_rd(10'h09c, rd);
    `CHK("unmapped", 8'h00, rd)
    `CHK("powered", 1'b1, div_powered_out)
    `CHK("ch3_oe", 3'b111, ch3_oe_out)
    `CHK("ch2_oe", 3'b111, ch2_oe_out)
    `CHK("ch3_corr", 1'b1, ch3_duty_cycle_correction_out)
    `CHK("ch2_corr", 1'b1, ch2_duty_cycle_correction_out)
    // Phase lengths, written only once sync has parked the divider
    foreach (rows[i]) begin
      sync_n_in = 1'b0;
      tick(4);
      reg_wr(channel_clock_divider_pkg::ADDR_DIV3_PHASE_LENGTHS, rows[i].cfg);
      sync_n_in = 1'b1;
      tick(80);
      `CHK("low_len", rows[i].lo, low_len)
      `CHK("high_len", rows[i].hi, high_len)
      `CHK("period", rows[i].lo + rows[i].hi, low_len + high_len)
    end
    // Sync obeyed: held at start level, forcing ignored without ignore-sync
    reg_wr(channel_clock_divider_pkg::ADDR_DIV3_CONTROL, 8'h20);
    sync_n_in = 1'b0;
    tick(6);
    reg_wr(channel_clock_divider_pkg::ADDR_DIV3_PHASE_LENGTHS, 8'h00);
    chk_static(1'b0, "held_low");
    reg_wr(channel_clock_divider_pkg::ADDR_DIV3_CONTROL, 8'h10);
    tick(2);
    chk_static(1'b1, "held_high");
    first_fall(n0);
    // Same start with an offset of four cycles
    sync_n_in = 1'b0;
    tick(6);
    reg_wr(channel_clock_divider_pkg::ADDR_DIV3_CONTROL, 8'h14);
    tick(2);
    first_fall(n1);
    `CHK("offset", 4, n1 - n0)
    // Software sets ignore-sync with the forced level
    reg_wr(channel_clock_divider_pkg::ADDR_DIV3_CONTROL, 8'h40);
    sync_n_in = 1'b0;
    tick(6);
    chk_static(1'b0, "forced_low");
    reg_wr(channel_clock_divider_pkg::ADDR_DIV3_CONTROL, 8'h60);
    tick(2);
    chk_static(1'b1, "forced_high");
    sync_n_in = 1'b1;
    // Bypass routes the raw clock
    reg_wr(channel_clock_divider_pkg::ADDR_DIV3_CONTROL, 8'h80);
    `CHK("powered", 1'b0, div_powered_out)
    @(posedge clk_sys_in);
    #5;
    `CHK("bypass_hi", 1'b1, div_clk_out)
    #10;
    `CHK("bypass_lo", 1'b0, div_clk_out)
    tick(1);
    // Power-down and correction bits, reserved bits read zero
    reg_wr(channel_clock_divider_pkg::ADDR_CH3_POWER_CORR, 8'hff);
    reg_rd(channel_clock_divider_pkg::ADDR_CH3_POWER_CORR, rd);
    `CHK("ch3_reg", 8'h05, rd)
    `CHK("ch3_oe", 3'b000, ch3_oe_out)
    `CHK("ch3_corr", 1'b0, ch3_duty_cycle_correction_out)
    `CHK("ch2_oe", 3'b111, ch2_oe_out)
    reg_wr(channel_clock_divider_pkg::ADDR_CH2_POWER_CORR, 8'h04);
    reg_rd(channel_clock_divider_pkg::ADDR_CH2_POWER_CORR, rd);
    `CHK("ch2_reg", 8'h04, rd)
    `CHK("ch2_oe", 3'b000, ch2_oe_out)
    `CHK("ch2_corr", 1'b1, ch2_duty_cycle_correction_out)
    reg_wr(channel_clock_divider_pkg::ADDR_CH2_POWER_CORR, 8'h01);
    `CHK("ch2_oe", 3'b111, ch2_oe_out)
    `CHK("ch2_corr", 1'b0, ch2_duty_cycle_correction_out)
    // Reset in bypass must bring the set bypass, power-down and correction bits back to default
    srst_in = 1'b1;
    tick(3);
    srst_in = 1'b0;
    reg_rd(channel_clock_divider_pkg::ADDR_CH2_POWER_CORR, rd);
    `CHK("ch2_reg_rst", 8'h00, rd)
    `CHK("ch3_oe_rst", 3'b111, ch3_oe_out)
    `CHK("ch3_corr_rst", 1'b1, ch3_duty_cycle_correction_out)
    `CHK("powered_rst", 1'b1, div_powered_out)
    stop_test();
  end
endmodule : testbench
